// file: include/mem_map_pkg.sv
package mem_map_pkg;

    // ****************************************
    // Address spaces
    // ****************************************
    localparam logic [7:0]  DIRECT_RAM_TOP   = 8'h7F;
    localparam logic [7:0]  BIT_RAM_BASE     = 8'h20;
    localparam logic [7:0]  BIT_RAM_LIMIT    = 8'h7F;
    localparam int          BANK_LSB         = 3;
    localparam int          BANK_MSB         = 4;
    localparam logic [15:0] FLASH_TOP_SMALL  = 16'h5FFF;
    localparam logic [15:0] FLASH_TOP_LARGE  = 16'h7FFF;
    localparam logic [15:0] VECTOR_TOP       = 16'h0052;
    localparam logic [15:0] BOOT_BASE        = 16'hF800;
    localparam logic [15:0] ID_TOP           = 16'h01FF;
    localparam logic [15:0] FACTORY_ID_TOP   = 16'h007F;
    localparam logic [15:0] EXTRA_RAM_TOP    = 16'h03FF;
    localparam logic [15:0] EXTRA_RAM_STEP   = 16'h0100;

    // ****************************************
    // Fetch timing
    // ****************************************
    localparam int          CLOCK_MHZ        = 20;
    localparam int          SLOT_CYCLES      = 3;
    localparam logic [1:0]  PHASE_LAST       = 2'(SLOT_CYCLES - 1);
    localparam logic [1:0]  COMPAT_FETCH     = 2'(SLOT_CYCLES);
    localparam logic [1:0]  FAST_FETCH       = 2'h1;
    localparam int          FIFO_DEPTH       = 8;
    localparam int          FIFO_WIDTH       = 8;

    // ****************************************
    // Enumerations
    // ****************************************
    typedef enum logic [1:0] {
        ACC_DIRECT   = 2'b00,
        ACC_INDIRECT = 2'b01,
        ACC_REGISTER = 2'b10,
        ACC_BIT      = 2'b11
    } access_kind_t;

    typedef enum logic [1:0] {
        FETCH_IDLE     = 2'b00,
        FETCH_INTERNAL = 2'b01,
        FETCH_EXT_WAIT = 2'b10,
        FETCH_EXT_RUN  = 2'b11
    } fetch_state_t;

endpackage

// file: logic/byte_fifo.sv
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset_n,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    wire              doPush = inValid && inReady;
    wire              doPop  = outValid && outReady;

    assign inReady  = count != (AW+1)'(DEPTH);
    assign outValid = count != '0;
    assign outData  = store[rdPtr];

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doPush) wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            if (doPop) rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end

    // Storage has no reset: only entries below count are ever read
    always_ff @(posedge mclk) begin
        if (doPush) store[wrPtr] <= inData;
    end
endmodule

// file: logic/mem_map_fetch.sv
module mem_map_fetch (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    // Configuration
    input  wire logic                  fastMode,
    input  wire logic                  smallFlash,
    input  wire logic                  latch_strobe_disable,
    input  wire logic [2:0]            extra_ram_size,
    input  wire logic                  securityActive,
    input  wire logic [7:0]            program_status_word,
    // Internal data access decode
    input  wire mem_map_pkg::access_kind_t accKind,
    input  wire logic [7:0]            accAddr,
    output logic                       ramSelect,
    output logic                       ioSelect,
    output logic [7:0]                 ramAddr,
    output logic [7:0]                 ioAddr,
    output logic [2:0]                 bitPos,
    // External data space decode
    input  wire logic [15:0]           dataAddr,
    output logic                       extraRamSelect,
    output logic                       externalDataSelect,
    // Signature and boot space decode
    input  wire logic                  idRequest,
    input  wire logic                  idWrite,
    input  wire logic [15:0]           idAddr,
    output logic                       idReadEnable,
    output logic                       idWriteEnable,
    output logic                       factoryIdSelect,
    input  wire logic [15:0]           bootAddr,
    output logic                       bootSelect,
    // Code fetch request
    input  wire logic                  fetchRequest,
    input  wire logic [15:0]           fetchAddr,
    output logic                       fetchBusy,
    output logic                       vectorFetch,
    // Internal flash
    output logic                       flashRead,
    output logic [15:0]                flashAddr,
    input  wire logic [7:0]            flashData,
    // Fetched byte stream
    output logic                       codeValid,
    input  wire logic                  codeReady,
    output logic [7:0]                 codeByte,
    // External program memory pins
    output logic                       addressLatchStrobe,
    output logic                       addressLatchDrive,
    output logic                       programStoreStrobe_n,
    output logic [7:0]                 portTwo,
    output logic [7:0]                 portZeroOut,
    output logic                       portZeroOe,
    input  wire logic [7:0]            portZeroIn
);

    // ****************************************
    // Internal data decode
    // ****************************************
    wire        isDirect   = accKind == mem_map_pkg::ACC_DIRECT;
    wire        isIndirect = accKind == mem_map_pkg::ACC_INDIRECT;
    wire        isRegister = accKind == mem_map_pkg::ACC_REGISTER;
    wire        isBit      = accKind == mem_map_pkg::ACC_BIT;
    wire        lowHalf    = accAddr <= mem_map_pkg::DIRECT_RAM_TOP;
    wire [1:0]  bank       = program_status_word[mem_map_pkg::BANK_MSB:mem_map_pkg::BANK_LSB];
    wire [7:0]  regAddr    = {3'h0, bank, accAddr[2:0]};
    wire [7:0]  bitRamAddr = mem_map_pkg::BIT_RAM_BASE + {4'h0, accAddr[6:3]};
    wire [7:0]  bitIoAddr  = {accAddr[7:3], 3'h0};
    // Indirect ignores the upper half split: no I/O register is ever reached
    wire        next_ramSelect = isIndirect || isRegister
                                 || (isDirect && lowHalf)
                                 || (isBit && lowHalf);
    wire        next_ioSelect  = (isDirect || isBit) && !lowHalf;
    wire [7:0]  next_ramAddr   = isRegister ? regAddr
                               : (isBit ? bitRamAddr : accAddr);
    wire [7:0]  next_ioAddr    = isBit ? bitIoAddr : accAddr;

    // ****************************************
    // External data, signature and boot decode
    // ****************************************
    wire [15:0] extraLimit = 16'({extra_ram_size, 8'h00}) + mem_map_pkg::EXTRA_RAM_STEP;
    wire [15:0] extraTop   = (extraLimit > mem_map_pkg::EXTRA_RAM_TOP)
                           ? mem_map_pkg::EXTRA_RAM_TOP + 16'h0001 : extraLimit;
    wire        next_extraRam = dataAddr < extraTop;
    wire        idInRange     = idAddr <= mem_map_pkg::ID_TOP;
    wire        next_idRead   = idRequest && !idWrite && idInRange;
    wire        next_idWrite  = idRequest && idWrite && idInRange && !securityActive;
    wire        next_bootSel  = bootAddr >= mem_map_pkg::BOOT_BASE;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ramSelect          <= 1'b0;
            ioSelect           <= 1'b0;
            ramAddr            <= 8'h00;
            ioAddr             <= 8'h00;
            bitPos             <= 3'h0;
            extraRamSelect     <= 1'b0;
            externalDataSelect <= 1'b0;
            idReadEnable       <= 1'b0;
            idWriteEnable      <= 1'b0;
            factoryIdSelect    <= 1'b0;
            bootSelect         <= 1'b0;
        end else begin
            ramSelect          <= next_ramSelect;
            ioSelect           <= next_ioSelect;
            ramAddr            <= next_ramAddr;
            ioAddr             <= next_ioAddr;
            bitPos             <= accAddr[2:0];
            extraRamSelect     <= next_extraRam;
            externalDataSelect <= !next_extraRam;
            idReadEnable       <= next_idRead;
            idWriteEnable      <= next_idWrite;
            factoryIdSelect    <= idAddr <= mem_map_pkg::FACTORY_ID_TOP;
            bootSelect         <= next_bootSel;
        end
    end

    // ****************************************
    // Fetch sequencing
    // ****************************************
    mem_map_pkg::fetch_state_t state;
    mem_map_pkg::fetch_state_t next_state;
    logic [1:0]  phase;
    logic [1:0]  waitCount;
    logic [15:0] heldAddr;
    logic        pushValid;
    logic [7:0]  pushData;
    wire         fifoReady;

    wire [15:0] flashTop  = smallFlash ? mem_map_pkg::FLASH_TOP_SMALL
                                       : mem_map_pkg::FLASH_TOP_LARGE;
    // Only the address and smallFlash decide: no pin can push a flash address outside
    wire        goExternal = fetchAddr > flashTop;
    // A push still on its way has not reached the buffer count yet
    wire        accept     = state == mem_map_pkg::FETCH_IDLE && fetchRequest
                             && fifoReady && !pushValid;
    wire        phaseEnd   = phase == mem_map_pkg::PHASE_LAST;
    wire [1:0]  next_phase = phaseEnd ? 2'h0 : phase + 2'h1;
    // Compat internal fetch matches the three-clock external slot
    wire [1:0]  intCycles  = fastMode ? mem_map_pkg::FAST_FETCH
                                      : mem_map_pkg::COMPAT_FETCH;
    wire        intDone    = state == mem_map_pkg::FETCH_INTERNAL && waitCount == 2'h1;
    wire        extCapture = state == mem_map_pkg::FETCH_EXT_RUN && phaseEnd;
    wire        extSlotNext = (state == mem_map_pkg::FETCH_EXT_WAIT && phaseEnd)
                            || (state == mem_map_pkg::FETCH_EXT_RUN && !phaseEnd);

    always_comb begin
        next_state = state;
        case (state)
            mem_map_pkg::FETCH_IDLE: begin
                if (accept)
                    next_state = goExternal ? mem_map_pkg::FETCH_EXT_WAIT
                                            : mem_map_pkg::FETCH_INTERNAL;
            end
            mem_map_pkg::FETCH_INTERNAL: begin
                if (intDone) next_state = mem_map_pkg::FETCH_IDLE;
            end
            mem_map_pkg::FETCH_EXT_WAIT: begin
                if (phaseEnd) next_state = mem_map_pkg::FETCH_EXT_RUN;
            end
            mem_map_pkg::FETCH_EXT_RUN: begin
                if (phaseEnd) next_state = mem_map_pkg::FETCH_IDLE;
            end
            default: next_state = mem_map_pkg::FETCH_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state     <= mem_map_pkg::FETCH_IDLE;
            phase     <= 2'h0;
            waitCount <= 2'h0;
            heldAddr  <= 16'h0000;
        end else begin
            state <= next_state;
            phase <= next_phase;
            if (accept) heldAddr <= fetchAddr;
            if (accept) waitCount <= intCycles;
            else if (waitCount != 2'h0) waitCount <= waitCount - 2'h1;
        end
    end

    // One fetch in flight, so a slot checked at accept cannot vanish
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pushValid   <= 1'b0;
            pushData    <= 8'h00;
            fetchBusy   <= 1'b0;
            vectorFetch <= 1'b0;
            flashRead   <= 1'b0;
            flashAddr   <= 16'h0000;
        end else begin
            pushValid   <= intDone || extCapture;
            pushData    <= extCapture ? portZeroIn : flashData;
            fetchBusy   <= next_state != mem_map_pkg::FETCH_IDLE;
            vectorFetch <= accept && fetchAddr <= mem_map_pkg::VECTOR_TOP;
            flashRead   <= accept && !goExternal;
            if (accept) flashAddr <= fetchAddr;
        end
    end

    // ****************************************
    // External strobes and ports
    // ****************************************
    // Strobe keeps running between fetches unless disabled
    wire aleRunning = !latch_strobe_disable || extSlotNext;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            addressLatchStrobe   <= 1'b1;
            addressLatchDrive    <= 1'b0;
            programStoreStrobe_n <= 1'b1;
            portTwo              <= 8'h00;
            portZeroOut          <= 8'h00;
            portZeroOe           <= 1'b0;
        end else begin
            addressLatchStrobe   <= aleRunning ? (next_phase == 2'h0) : 1'b1;
            addressLatchDrive    <= aleRunning;
            programStoreStrobe_n <= !(extSlotNext && next_phase != 2'h0);
            if (extSlotNext && next_phase == 2'h0) begin
                portTwo     <= heldAddr[15:8];
                portZeroOut <= heldAddr[7:0];
            end
            portZeroOe <= extSlotNext && next_phase == 2'h0;
        end
    end

    // ****************************************
    // Fetched byte buffer
    // ****************************************
    // Fast mode fills slower externally: each byte costs a full slot
    byte_fifo #(
        .WIDTH (mem_map_pkg::FIFO_WIDTH),
        .DEPTH (mem_map_pkg::FIFO_DEPTH)
    ) codeBuffer (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .inValid  (pushValid),
        .inReady  (fifoReady),
        .inData   (pushData),
        .outValid (codeValid),
        .outReady (codeReady),
        .outData  (codeByte)
    );

    // ****************************************
    // Checks
    // ****************************************
    sequence extStart_s;
        state == mem_map_pkg::FETCH_EXT_WAIT && phaseEnd;
    endsequence
    sequence extSlot_s;
        !programStoreStrobe_n && portZeroOe == 1'b0 [*1] ##1 !programStoreStrobe_n;
    endsequence

    strobe_slot_a: assert property (@(posedge mclk) disable iff (!reset_n)
        extStart_s |=> addressLatchStrobe && portZeroOe ##1 extSlot_s ##1 programStoreStrobe_n)
        else $error("external slot strobe order wrong");
    store_duty_a: assert property (@(posedge mclk) disable iff (!reset_n)
        $fell(programStoreStrobe_n) |=> !programStoreStrobe_n ##1 programStoreStrobe_n)
        else $error("store strobe low time wrong");
    ale_rate_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !latch_strobe_disable && !$past(latch_strobe_disable) && addressLatchStrobe
        ##1 !latch_strobe_disable
        |-> !addressLatchStrobe ##1 !addressLatchStrobe)
        else $error("latch strobe duty wrong");
    addr_high_a: assert property (@(posedge mclk) disable iff (!reset_n)
        extStart_s |=> portTwo == heldAddr[15:8] && portZeroOut == heldAddr[7:0])
        else $error("fetch address not on ports");
    release_p0_a: assert property (@(posedge mclk) disable iff (!reset_n)
        $fell(programStoreStrobe_n) |-> !portZeroOe && $past(portZeroOe))
        else $error("port zero not released");
    capture_byte_a: assert property (@(posedge mclk) disable iff (!reset_n)
        extCapture |=> pushValid && pushData == $past(portZeroIn))
        else $error("instruction byte not captured");
    no_force_ext_a: assert property (@(posedge mclk) disable iff (!reset_n)
        accept && fetchAddr <= flashTop |=> state == mem_map_pkg::FETCH_INTERNAL && flashRead)
        else $error("flash address fetched outside");
    fast_int_a: assert property (@(posedge mclk) disable iff (!reset_n)
        accept && !goExternal && fastMode |=> ##1 pushValid)
        else $error("fast internal fetch not one clock");
    compat_int_a: assert property (@(posedge mclk) disable iff (!reset_n)
        accept && !goExternal && !fastMode |=> !pushValid [*3] ##1 pushValid)
        else $error("compat internal fetch not three clocks");
    io_indirect_a: assert property (@(posedge mclk) disable iff (!reset_n)
        isIndirect |=> !ioSelect && ramSelect && ramAddr == $past(accAddr))
        else $error("indirect reached io space");
    bank_reg_a: assert property (@(posedge mclk) disable iff (!reset_n)
        isRegister |=> ramAddr[7:5] == 3'h0 && ramAddr[4:3] == $past(bank))
        else $error("register bank wrong");
    id_write_lock_a: assert property (@(posedge mclk) disable iff (!reset_n)
        securityActive |=> !idWriteEnable)
        else $error("signature write under security");
endmodule

// file: verif/ext_rom_model.sv
module ext_rom_model (
    // Clock
    input  wire logic       mclk,
    // Strobes and address from the fetcher
    input  wire logic       addressLatchStrobe,
    input  wire logic       programStoreStrobe_n,
    input  wire logic [7:0] portTwo,
    input  wire logic [7:0] portZeroOut,
    input  wire logic       portZeroOe,
    // Resolved port zero wire
    output logic      [7:0] portZeroIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lowAddr   = 8'h00;
    logic [7:0] lastLevel = 8'h00;
    logic [7:0] romData;
    // Low byte held by the outside latch, port two used live
    always @(posedge mclk) if (addressLatchStrobe) lowAddr <= portZeroOut;
    assign romData = lowAddr ^ {portTwo[3:0], portTwo[7:4]};
    // ROM drives only while store strobe low
    // Released wire has no pull: it flips every cycle so stale data never matches
    assign portZeroIn = portZeroOe ? portZeroOut : (!programStoreStrobe_n ? romData : ~lastLevel);
    always @(posedge mclk) lastLevel <= portZeroIn;
endmodule

// file: verif/test_mem_map_fetch.sv
module test_mem_map_fetch;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 0, reset_n = 0, fastMode = 1, smallFlash = 1, latch_strobe_disable = 0;
    logic        securityActive = 0, idRequest = 1, idWrite = 0, fetchRequest = 0;
    logic        codeReady = 0;
    logic [2:0]  extra_ram_size = 3'h1, bitPos;
    logic [7:0]  program_status_word = 8'h10, accAddr = 8'h00, ramAddr, ioAddr, codeByte;
    logic [7:0]  portTwo, portZeroOut, portZeroIn, flashData;
    logic [15:0] dataAddr = 16'h0000, idAddr = 16'h0000, bootAddr = 16'h0000;
    logic [15:0] fetchAddr = 16'h0000, flashAddr;
    logic        ramSelect, ioSelect, extraRamSelect, externalDataSelect, idReadEnable;
    logic        idWriteEnable, factoryIdSelect, bootSelect, fetchBusy, vectorFetch;
    logic        flashRead, codeValid, addressLatchStrobe, addressLatchDrive;
    logic        programStoreStrobe_n, portZeroOe;
    mem_map_pkg::access_kind_t accKind = mem_map_pkg::ACC_DIRECT;
    int          n_fail = 0, total_checks = 0;

    // Flash answers from the address it is given
    assign flashData = flashAddr[7:0] ^ 8'hA5;
    mem_map_fetch DUT (.mclk, .reset_n, .fastMode, .smallFlash, .latch_strobe_disable,
        .extra_ram_size, .securityActive, .program_status_word, .accKind, .accAddr,
        .ramSelect, .ioSelect, .ramAddr, .ioAddr, .bitPos, .dataAddr, .extraRamSelect,
        .externalDataSelect, .idRequest, .idWrite, .idAddr, .idReadEnable,
        .idWriteEnable, .factoryIdSelect, .bootAddr, .bootSelect, .fetchRequest,
        .fetchAddr, .fetchBusy, .vectorFetch, .flashRead, .flashAddr, .flashData,
        .codeValid, .codeReady, .codeByte, .addressLatchStrobe, .addressLatchDrive,
        .programStoreStrobe_n, .portTwo, .portZeroOut, .portZeroOe, .portZeroIn);
    ext_rom_model rom (.mclk, .addressLatchStrobe, .programStoreStrobe_n, .portTwo,
        .portZeroOut, .portZeroOe, .portZeroIn);

    initial forever #25 mclk = ~mclk;

    function automatic logic [7:0] rom_byte(input logic [15:0] a);
        return a[7:0] ^ {a[11:8], a[15:12]};
    endfunction

    task check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task decode(input mem_map_pkg::access_kind_t k, input logic [7:0] a, input logic io,
                input logic [7:0] ex, input logic [2:0] eb);
        @(posedge mclk);
        accKind <= k;
        accAddr <= a;
        @(posedge mclk);
        #1;
        check(16'({ramSelect, ioSelect}), 16'({!io, io}));
        check(16'(io ? ioAddr : ramAddr), 16'(ex));
        check(16'(bitPos), 16'(eb));
    endtask

    task space(input logic [15:0] d, s, input logic w, sec, input logic [15:0] b,
               input logic [5:0] e);
        @(posedge mclk);
        dataAddr <= d;
        idAddr <= s;
        idWrite <= w;
        securityActive <= sec;
        bootAddr <= b;
        @(posedge mclk);
        #1;
        check(16'({extraRamSelect, externalDataSelect, idReadEnable, idWriteEnable,
                   factoryIdSelect, bootSelect}), 16'(e));
    endtask

    task fetch(input logic [15:0] a, input logic [7:0] eb, input logic ev, ef, pop);
        logic sawVec, sawFlash, done;
        sawVec = 0;
        sawFlash = 0;
        done = 0;
        @(posedge mclk);
        fetchRequest <= 1'b1;
        fetchAddr <= a;
        for (int n = 0; n < 40; n++) begin
            @(posedge mclk);
            sawVec |= (vectorFetch === 1'b1);
            sawFlash |= (flashRead === 1'b1);
            // Request held until the fetcher shows it took it
            if (fetchBusy === 1'b1) fetchRequest <= 1'b0;
            if (fetchRequest === 1'b0 && codeValid === 1'b1) begin
                done = 1;
                break;
            end
        end
        // A fetch that never lands counts against the run
        if (!done) fetchRequest <= 1'b0;
        check(16'(done), 16'h0001);
        check(16'(sawVec), 16'(ev));
        check(16'(sawFlash), 16'(ef));
        if (pop) begin
            check(16'(codeByte), 16'(eb));
            codeReady <= 1'b1;
            @(posedge mclk);
            codeReady <= 1'b0;
        end
    endtask

    task test_decode;
        decode(mem_map_pkg::ACC_DIRECT, 8'h7F, 0, 8'h7F, 3'h7);
        decode(mem_map_pkg::ACC_DIRECT, 8'h80, 1, 8'h80, 3'h0);
        decode(mem_map_pkg::ACC_INDIRECT, 8'h90, 0, 8'h90, 3'h0);
        decode(mem_map_pkg::ACC_REGISTER, 8'h05, 0, 8'h15, 3'h5);
        decode(mem_map_pkg::ACC_BIT, 8'h00, 0, 8'h20, 3'h0);
        decode(mem_map_pkg::ACC_BIT, 8'h7F, 0, 8'h2F, 3'h7);
        $display("test_decode done");
    endtask

    task test_spaces;
        space(16'h01FF, 16'h01FF, 0, 1, 16'hF800, 6'b101001);
        space(16'h0200, 16'h0200, 1, 0, 16'hF7FF, 6'b010000);
        space(16'h0000, 16'h007F, 1, 0, 16'hFFFF, 6'b100111);
        space(16'hFFFF, 16'h0080, 1, 1, 16'h0000, 6'b010000);
        $display("test_spaces done");
    endtask

    task test_fetch;
        fetch(16'h0052, 8'h52 ^ 8'hA5, 1, 1, 1);
        fetch(16'h0053, 8'h53 ^ 8'hA5, 0, 1, 1);
        fetch(16'h5FFF, 8'hFF ^ 8'hA5, 0, 1, 1);
        // Strobe parked high before the fast-mode jump outside
        latch_strobe_disable <= 1'b1;
        fetch(16'h6000, rom_byte(16'h6000), 0, 0, 1);
        smallFlash <= 1'b0;
        fastMode <= 1'b0;
        latch_strobe_disable <= 1'b0;
        fetch(16'h6000, 8'h00 ^ 8'hA5, 0, 1, 1);
        fetch(16'hFFFF, rom_byte(16'hFFFF), 0, 0, 1);
        fetch(16'h8001, rom_byte(16'h8001), 0, 0, 1);
        fastMode <= 1'b1;
        $display("test_fetch done");
    endtask

    task test_fill;
        logic busySeen;
        busySeen = 0;
        for (int i = 0; i < 8; i++) fetch(16'h0100 + 16'(i), 8'h00, 0, 1, 0);
        repeat (10) @(posedge mclk);
        fetchRequest <= 1'b1;
        repeat (20) @(posedge mclk) busySeen |= (fetchBusy === 1'b1);
        fetchRequest <= 1'b0;
        check(16'(busySeen), 16'h0000);
        codeReady <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            check(16'(codeByte), 16'(8'(i) ^ 8'hA5));
        end
        codeReady <= 1'b0;
        #1;
        check(16'(codeValid), 16'h0000);
        $display("test_fill done");
    endtask

    task test_strobe;
        int hi;
        hi = 0;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 9; i++) @(posedge mclk) hi += (addressLatchStrobe === 1'b1);
        check(16'(hi), 16'h0003);
        check(16'(addressLatchDrive), 16'h0001);
        latch_strobe_disable <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        check(16'({addressLatchStrobe, addressLatchDrive}), 16'h0002);
        $display("test_strobe done");
    endtask

    task close_out;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        test_decode;
        test_spaces;
        test_fetch;
        test_fill;
        test_strobe;
        close_out;
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #200000;
        n_fail++;
        close_out;
    end
endmodule
